// *** rtl/scr_cfg.svh ***
/*
  Offsets, field positions, reset values, command codes and edge counts
  of the serial command interpreter. Assumes inclusion by bare name.
*/
`ifndef SCR_CFG_SVH
`define SCR_CFG_SVH

// ==========================================================
// register offsets
`define SCR_REG_MUX_AND_ADC_BUFFER_BIAS 8'h00
`define SCR_REG_OUTPUT_FORMAT_AND_AUX 8'h01

// ==========================================================
// reset values (power-up contents are undefined, zero chosen)
`define SCR_R0_RST 16'h0000
`define SCR_R1_RST 16'h0000

// ==========================================================
// register 0 fields
`define SCR_R0_MUX_MSB 5
`define SCR_R0_MUX_LSB 0
`define SCR_R0_BUF_MSB 11
`define SCR_R0_BUF_LSB 6

// ==========================================================
// register 1 fields
`define SCR_R1_CUT_MSB 3
`define SCR_R1_CUT_LSB 0
`define SCR_R1_OFFREM 4
`define SCR_R1_ABS 5
`define SCR_R1_TWOS 6
`define SCR_R1_WEAK 7
`define SCR_R1_AFLOAT 8
`define SCR_R1_AVALUE 9
`define SCR_R1_BFLOAT 10
`define SCR_R1_BVALUE 11
`define SCR_R1_OD 12

// ==========================================================
// command word layout and codes
`define SCR_OP_MSB 31
`define SCR_OP_LSB 30
`define SCR_UFLAG 29
`define SCR_MFLAG 28
`define SCR_ADDR_MSB 23
`define SCR_ADDR_LSB 16
`define SCR_DATA_MSB 15
`define SCR_DATA_LSB 0
`define SCR_CMD_CLEAR 32'h6A000000
`define SCR_CMD_CALIBRATE 32'h55000000

// ==========================================================
// frame timing in serial clock pulses
`define SCR_FRAME_BITS 6'd32
`define SCR_WRITE_EDGE 6'd4
`define SCR_UPDATE_EDGE 6'd17
`define SCR_CNT_MAX 6'h3F

`endif

// *** rtl/scr_pkg.sv ***
/*
  Types of the serial command interpreter.
  Assumes nothing of its surroundings.
*/
package scr_pkg;

  // ==========================================================
  // command classes, from the top two bits of a frame
  typedef enum logic [1:0] {
    SCR_OP_CONVERT = 2'b00,
    SCR_OP_CALIB = 2'b01,
    SCR_OP_WRITE = 2'b10,
    SCR_OP_READ = 2'b11
  } scr_op_t;

  // ==========================================================
  // link state, gray coded along idle, receive, overrun
  typedef enum logic [1:0] {
    SCR_LK_IDLE = 2'b00,
    SCR_LK_RECV = 2'b01,
    SCR_LK_OVER = 2'b11
  } scr_link_t;

endpackage

// *** rtl/scr_sync.sv ***
/*
  Two-flop synchroniser, one per bit.
  Assumes inputs asynchronous to clk_sys; first stage feeds only second.
*/
`timescale 1ns/1ns
module scr_sync #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // asynchronous in, synchronous out
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  // ==========================================================
  // per-bit stages
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic stage1_r;
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          stage1_r <= 1'b0;
          syncOut[gi] <= 1'b0;
        end else begin
          stage1_r <= asyncIn[gi];
          syncOut[gi] <= stage1_r;
        end
      end
    end
  endgenerate

endmodule

// *** rtl/scr_resp.sv ***
/*
  Builds the 32-bit answer to one received command word.
  Assumes read data already selected by the caller.
*/
`timescale 1ns/1ns
`include "scr_cfg.svh"
module scr_resp (
  // received command
  input wire logic [31:0] cmdWord,
  // state that shapes the answer
  input wire logic [15:0] readData,
  input wire logic twosComp,
  // answer
  output logic [31:0] respWord
);

  scr_pkg::scr_op_t op;

  assign op = scr_pkg::scr_op_t'(cmdWord[`SCR_OP_MSB:`SCR_OP_LSB]);

  // ==========================================================
  // answer per command class
  always_comb begin
    case (op)
      // every 01 word, known or not, answers alike
      scr_pkg::SCR_OP_CALIB: begin
        respWord = {~twosComp, 31'h00000000};
      end
      scr_pkg::SCR_OP_WRITE: begin
        respWord = {16'hFFFF, cmdWord[`SCR_DATA_MSB:`SCR_DATA_LSB]};
      end
      scr_pkg::SCR_OP_READ: begin
        respWord = {16'h0000, readData};
      end
      // conversions are handled elsewhere; answer zero here
      default: begin
        respWord = 32'h00000000;
      end
    endcase
  end

endmodule

// *** rtl/scr_cmd_regs.sv ***
/*
  Serial command interpreter with configuration registers 0 and 1.
  Assumes an SPI master on sclk, csN, mosi, all asynchronous to clk_sys
  and sampled here; the serial clock must be slower than clk_sys / 4.
*/
`timescale 1ns/1ns
`include "scr_cfg.svh"
module scr_cmd_regs (
  // system
  input wire logic clk_sys,
  input wire logic rstn,
  // serial link pins
  input wire logic sclk,
  input wire logic csN,
  input wire logic mosi,
  input wire logic lvdsMode,
  output logic misoOut,
  output logic misoOe,
  output logic misoWeak,
  // register 0 fields
  output logic [5:0] analog_select_bias,
  output logic [5:0] adcBufferBias,
  // register 1 fields
  output logic [3:0] offsetCutoff,
  output logic offset_removal_enable,
  output logic absMode,
  output logic twosComp,
  // auxiliary pins
  output logic aux_pin_a_out,
  output logic aux_pin_a_oe,
  output logic aux_pin_b_out,
  output logic aux_pin_b_oe,
  output logic open_drain_pin_out,
  output logic open_drain_pin_oe,
  // one-cycle events to the rest of the chip
  output logic adcCalInit,
  output logic trigUpdate,
  output logic monitorClear
);

  // ==========================================================
  // pin synchronisation
  logic [3:0] pinSync;
  logic sclkS, csNS, mosiS, lvdsS;

  scr_sync #(.WIDTH(4)) u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .asyncIn({lvdsMode, mosi, ~csN, sclk}), // select resets to idle high
    .syncOut(pinSync)
  );

  assign sclkS = pinSync[0];
  assign csNS = ~pinSync[1];
  assign mosiS = pinSync[2];
  assign lvdsS = pinSync[3];

  // ==========================================================
  // edge detection on the synchronised copies
  logic sclkPrev_r, csNPrev_r;
  logic sclkRise, sclkFall, csFall, csRise;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sclkPrev_r <= 1'b0;
      csNPrev_r <= 1'b1;
    end else begin
      sclkPrev_r <= sclkS;
      csNPrev_r <= csNS;
    end
  end

  // clock edges count only while selected
  assign sclkRise = sclkS & ~sclkPrev_r & ~csNS;
  assign sclkFall = ~sclkS & sclkPrev_r & ~csNS;
  assign csFall = ~csNS & csNPrev_r;
  assign csRise = csNS & ~csNPrev_r;

  // ==========================================================
  // frame state and edge counters
  scr_pkg::scr_link_t link_r, link_nxt;
  logic [5:0] riseCnt_r, fallCnt_r;
  logic frameDone;

  always_comb begin
    link_nxt = link_r;
    case (link_r)
      scr_pkg::SCR_LK_IDLE: begin
        if (csFall) begin
          link_nxt = scr_pkg::SCR_LK_RECV;
        end
      end
      scr_pkg::SCR_LK_RECV: begin
        if (csRise) begin
          link_nxt = scr_pkg::SCR_LK_IDLE;
        end else if (sclkRise && riseCnt_r == `SCR_FRAME_BITS) begin
          link_nxt = scr_pkg::SCR_LK_OVER;
        end
      end
      scr_pkg::SCR_LK_OVER: begin
        if (csRise) begin
          link_nxt = scr_pkg::SCR_LK_IDLE;
        end
      end
      default: begin
        link_nxt = scr_pkg::SCR_LK_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      link_r <= scr_pkg::SCR_LK_IDLE;
    end else begin
      link_r <= link_nxt;
    end
  end

  // short or long frames are dropped whole
  assign frameDone = csRise && link_r == scr_pkg::SCR_LK_RECV
    && riseCnt_r == `SCR_FRAME_BITS;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      riseCnt_r <= 6'h00;
      fallCnt_r <= 6'h00;
    end else if (csFall) begin
      riseCnt_r <= 6'h00;
      fallCnt_r <= 6'h00;
    end else begin
      if (sclkRise && riseCnt_r != `SCR_CNT_MAX) begin
        riseCnt_r <= riseCnt_r + 6'h01;
      end
      if (sclkFall && fallCnt_r != `SCR_CNT_MAX) begin
        fallCnt_r <= fallCnt_r + 6'h01;
      end
    end
  end

  // ==========================================================
  // receive shift register, MSB first
  logic [31:0] rxShift_r;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rxShift_r <= 32'h00000000;
    end else if (sclkRise) begin
      rxShift_r <= {rxShift_r[30:0], mosiS};
    end
  end

  // ==========================================================
  // command decode
  scr_pkg::scr_op_t op;
  logic [7:0] cmdAddr;
  logic isWrite, isRead, flagged, addrWritable;
  logic [15:0] reg0_r, reg1_r, readData;
  logic [31:0] respWord;

  assign op = scr_pkg::scr_op_t'(rxShift_r[`SCR_OP_MSB:`SCR_OP_LSB]);
  assign cmdAddr = rxShift_r[`SCR_ADDR_MSB:`SCR_ADDR_LSB];
  assign isWrite = op == scr_pkg::SCR_OP_WRITE;
  assign isRead = op == scr_pkg::SCR_OP_READ;
  // flags act only in write and read frames
  assign flagged = isWrite | isRead;
  // only registers 0 and 1 exist; the rest of the space is absent
  assign addrWritable = cmdAddr == `SCR_REG_MUX_AND_ADC_BUFFER_BIAS
    || cmdAddr == `SCR_REG_OUTPUT_FORMAT_AND_AUX;

  // no triggered register here, so buffered equals stored value
  assign readData =
    (cmdAddr == `SCR_REG_MUX_AND_ADC_BUFFER_BIAS) ? reg0_r :
    (cmdAddr == `SCR_REG_OUTPUT_FORMAT_AND_AUX) ? reg1_r :
    16'h0000;

  scr_resp u_resp (
    .cmdWord(rxShift_r),
    .readData(readData),
    .twosComp(reg1_r[`SCR_R1_TWOS]),
    .respWord(respWord)
  );

  // ==========================================================
  // two-stage answer pipeline
  logic [31:0] respPend_r, txShift_r;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      respPend_r <= 32'h00000000;
      txShift_r <= 32'h00000000;
    end else if (frameDone) begin
      respPend_r <= respWord;
      txShift_r <= respPend_r;
    end else if (sclkFall) begin
      txShift_r <= {txShift_r[30:0], 1'b0};
    end
  end

  // ==========================================================
  // serial output pin
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      misoOut <= 1'b0;
      misoOe <= 1'b0;
      misoWeak <= 1'b0;
    end else begin
      if (csFall) begin
        misoOut <= txShift_r[31];
      end else if (sclkFall) begin
        misoOut <= txShift_r[30];
      end
      if (!csNS) begin
        misoOe <= 1'b1;
        misoWeak <= 1'b0;
      end else begin
        // differential drivers ignore the weak bit
        misoOe <= lvdsS | reg1_r[`SCR_R1_WEAK];
        misoWeak <= ~lvdsS & reg1_r[`SCR_R1_WEAK];
      end
    end
  end

  // ==========================================================
  // deferred register write
  logic wrPend_r, wrAddr1_r, wrApply;
  logic [15:0] wrData_r;

  assign wrApply = wrPend_r && sclkFall
    && fallCnt_r == `SCR_WRITE_EDGE - 6'd1;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wrPend_r <= 1'b0;
      wrAddr1_r <= 1'b0;
      wrData_r <= 16'h0000;
    end else if (frameDone) begin
      wrPend_r <= isWrite && addrWritable;
      wrAddr1_r <= cmdAddr[0];
      wrData_r <= rxShift_r[`SCR_DATA_MSB:`SCR_DATA_LSB];
    end else if (wrApply) begin
      wrPend_r <= 1'b0;
    end
  end

  // whole words only; reset value stands until software writes
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg0_r <= `SCR_R0_RST;
      reg1_r <= `SCR_R1_RST;
    end else if (wrApply) begin
      if (wrAddr1_r) begin
        reg1_r <= wrData_r;
      end else begin
        reg0_r <= wrData_r;
      end
    end
  end

  // ==========================================================
  // configuration outputs, all sliced from stored registers
  assign analog_select_bias = reg0_r[`SCR_R0_MUX_MSB:`SCR_R0_MUX_LSB];
  assign adcBufferBias = reg0_r[`SCR_R0_BUF_MSB:`SCR_R0_BUF_LSB];
  assign offsetCutoff = reg1_r[`SCR_R1_CUT_MSB:`SCR_R1_CUT_LSB];
  assign offset_removal_enable = reg1_r[`SCR_R1_OFFREM];
  assign absMode = reg1_r[`SCR_R1_ABS];
  assign twosComp = reg1_r[`SCR_R1_TWOS];

  // ==========================================================
  // auxiliary pins
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      aux_pin_a_out <= 1'b0;
      aux_pin_a_oe <= 1'b0;
      aux_pin_b_out <= 1'b0;
      aux_pin_b_oe <= 1'b0;
      open_drain_pin_out <= 1'b0;
      open_drain_pin_oe <= 1'b0;
    end else begin
      aux_pin_a_out <= reg1_r[`SCR_R1_AVALUE];
      aux_pin_a_oe <= ~reg1_r[`SCR_R1_AFLOAT];
      aux_pin_b_out <= reg1_r[`SCR_R1_BVALUE];
      aux_pin_b_oe <= ~reg1_r[`SCR_R1_BFLOAT];
      // low here stands for the negative stimulation supply
      open_drain_pin_out <= 1'b0;
      open_drain_pin_oe <= reg1_r[`SCR_R1_OD];
    end
  end

  // ==========================================================
  // chip-wide events
  logic updPend_r;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      updPend_r <= 1'b0;
      trigUpdate <= 1'b0;
      adcCalInit <= 1'b0;
      monitorClear <= 1'b0;
    end else begin
      trigUpdate <= 1'b0;
      // legacy calibrate only answers; it starts nothing
      adcCalInit <= frameDone && rxShift_r == `SCR_CMD_CLEAR;
      monitorClear <= frameDone && flagged
        && rxShift_r[`SCR_MFLAG];
      if (frameDone) begin
        updPend_r <= flagged & rxShift_r[`SCR_UFLAG];
      end else if (updPend_r && sclkFall
          && fallCnt_r == `SCR_UPDATE_EDGE - 6'd1) begin
        updPend_r <= 1'b0;
        trigUpdate <= 1'b1;
      end
    end
  end

endmodule

// *** test/scr_cmd_regs_assertions.sv ***
/*
  Concurrent checks on the ports of the serial command interpreter.
  Assumes one clk_sys domain and the bind at the foot of this file.
*/
`timescale 1ns/1ns
module scr_cmd_regs_checker (
  // system
  input wire logic clk_sys,
  input wire logic rstn,
  // link
  input wire logic csN,
  input wire logic lvdsMode,
  input wire logic misoOe,
  input wire logic misoWeak,
  // register fields and pins
  input wire logic twosComp,
  input wire logic [3:0] offsetCutoff,
  input wire logic open_drain_pin_out,
  // events
  input wire logic adcCalInit,
  input wire logic trigUpdate,
  input wire logic monitorClear
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // ==========================================================
  // pins
  property p_od_low;
    open_drain_pin_out == 1'b0;
  endproperty
  a_od_low: assert property (p_od_low)
    else $error("open drain pin driven high");
  property p_weak_oe;
    misoWeak |-> misoOe;
  endproperty
  a_weak_oe: assert property (p_weak_oe)
    else $error("weak drive without enable");
  property p_oe_frame;
    (!csN) [*4] |-> misoOe;
  endproperty
  a_oe_frame: assert property (p_oe_frame)
    else $error("serial output not driven in frame");
  property p_idle;
    (csN && !lvdsMode) [*4] |-> (misoOe == misoWeak);
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle serial output neither floating nor weak");
  property p_oe_lvds;
    (csN && lvdsMode) [*4] |-> misoOe && !misoWeak;
  endproperty
  a_oe_lvds: assert property (p_oe_lvds)
    else $error("differential output not strongly driven");

  // ==========================================================
  // events and register timing
  property p_cal;
    adcCalInit |-> csN && $past(csN, 2) ##1 !adcCalInit;
  endproperty
  a_cal: assert property (p_cal)
    else $error("calibration pulse misplaced");
  property p_mon;
    monitorClear |-> csN && $past(csN, 2) ##1 !monitorClear;
  endproperty
  a_mon: assert property (p_mon)
    else $error("monitor clear pulse misplaced");
  property p_trig;
    trigUpdate |-> !csN && $past(!csN, 8) ##1 !trigUpdate;
  endproperty
  a_trig: assert property (p_trig)
    else $error("update pulse outside a frame");
  property p_cfg;
    ($changed(twosComp) || $changed(offsetCutoff)) |-> !csN;
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("register changed outside a frame");
endmodule

bind scr_cmd_regs scr_cmd_regs_checker scr_cmd_regs_checker_i (
  .clk_sys(clk_sys), .rstn(rstn), .csN(csN), .lvdsMode(lvdsMode),
  .misoOe(misoOe), .misoWeak(misoWeak), .twosComp(twosComp),
  .offsetCutoff(offsetCutoff), .open_drain_pin_out(open_drain_pin_out),
  .adcCalInit(adcCalInit), .trigUpdate(trigUpdate),
  .monitorClear(monitorClear)
);

// *** test/scr_spi_master.sv ***
/*
  Behavioural serial master, 400 ns serial clock.
  Assumes the caller runs xfer from one process at a time.
*/
`timescale 1ns/1ns
module scr_spi_master (
  // system clock
  input wire logic clk_sys,
  // device answer
  input wire logic misoOut,
  input wire logic misoOe,
  // link pins
  output logic sclk,
  output logic csN,
  output logic mosi
);
  logic misoSeen = 1'b0;
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    mosi = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // ==========================================================
  // one frame; clock idles low between frames
  task automatic xfer(input logic [31:0] w, input int n,
      output logic [31:0] r);
    r = 32'h00000000;
    csN <= 1'b0;
    tick(4);
    for (int i = 0; i < n; i++) begin
      mosi <= w[31 - i];
      tick(4);
      sclk <= 1'b1;
      #1;
      // released line seen as the inverse of the last bit
      misoSeen = misoOe ? misoOut : ~misoSeen;
      r = {r[30:0], misoSeen};
      tick(4);
      sclk <= 1'b0;
    end
    tick(4);
    csN <= 1'b1;
    mosi <= ~mosi;
    tick(6);
  endtask
endmodule

// *** test/tb_top.sv ***
/*
  Self-checking bench of the serial command interpreter.
  Assumes scr_spi_master as link partner and the bound checker.
*/
`timescale 1ns/1ns
module tb_top;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic lvdsMode = 1'b0;
  logic sclk, csN, mosi, misoOut, misoOe, misoWeak;
  logic [5:0] analog_select_bias, adcBufferBias;
  logic [3:0] offsetCutoff;
  logic offset_removal_enable, absMode, twosComp;
  logic aux_pin_a_out, aux_pin_a_oe, aux_pin_b_out, aux_pin_b_oe;
  logic open_drain_pin_out, open_drain_pin_oe;
  logic adcCalInit, trigUpdate, monitorClear;
  logic [31:0] resp;
  int errors = 0;
  int cmp_count = 0;
  int calCnt = 0;
  int updCnt = 0;
  int monCnt = 0;
  // host sends clear first and sets every register it uses
  logic [31:0] cmdTab [17] = '{32'h6A000000, 32'h80010040, 32'hC0010000,
    32'h6A000000, 32'h7F000000, 32'h80000FFF, 32'h80051234, 32'hC0000000,
    32'hC0050000, 32'h80011AB5, 32'hD0010000, 32'hA0000000, 32'hC0000000,
    32'h55000000, 32'h00000000, 32'hC0010000, 32'hC0010000};
  logic [31:0] expTab [15] = '{32'h80000000, 32'hFFFF0040, 32'h00000040,
    32'h00000000, 32'h00000000, 32'hFFFF0FFF, 32'hFFFF1234, 32'h00000FFF,
    32'h00000000, 32'hFFFF1AB5, 32'h00001AB5, 32'hFFFF0000, 32'h00000000,
    32'h80000000, 32'h00000000};

  always #25 clk_sys = ~clk_sys;

  scr_cmd_regs scr_cmd_regs_i (.clk_sys(clk_sys), .rstn(rstn),
    .sclk(sclk), .csN(csN), .mosi(mosi), .lvdsMode(lvdsMode),
    .misoOut(misoOut), .misoOe(misoOe), .misoWeak(misoWeak),
    .analog_select_bias(analog_select_bias), .adcBufferBias(adcBufferBias),
    .offsetCutoff(offsetCutoff),
    .offset_removal_enable(offset_removal_enable), .absMode(absMode),
    .twosComp(twosComp), .aux_pin_a_out(aux_pin_a_out),
    .aux_pin_a_oe(aux_pin_a_oe), .aux_pin_b_out(aux_pin_b_out),
    .aux_pin_b_oe(aux_pin_b_oe), .open_drain_pin_out(open_drain_pin_out),
    .open_drain_pin_oe(open_drain_pin_oe), .adcCalInit(adcCalInit),
    .trigUpdate(trigUpdate), .monitorClear(monitorClear));
  scr_spi_master scr_spi_master_i (.clk_sys(clk_sys), .misoOut(misoOut),
    .misoOe(misoOe), .sclk(sclk), .csN(csN), .mosi(mosi));

  // ==========================================================
  // event pulse counters
  always @(posedge clk_sys) begin
    calCnt += (adcCalInit === 1'b1);
    updCnt += (trigUpdate === 1'b1);
    monCnt += (monitorClear === 1'b1);
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================================
  // watchdog, about nine times the expected run
  initial begin
    #3000000;
    errors++;
    $display("ERROR t=%0t run did not finish", $time);
    report_and_stop();
  end

  initial begin
    tick(4);
    check({20'h0, aux_pin_a_oe, twosComp, misoOe, offsetCutoff}, 32'h0);
    tick(4);
    rstn <= 1'b1;
    tick(6);
    // ordinary commands, answers two frames later
    for (int i = 0; i < 17; i++) begin
      scr_spi_master_i.xfer(cmdTab[i], 32, resp);
      if (i >= 2) check(resp, expTab[i - 2]);
    end
    check(calCnt, 2);
    check(updCnt, 1);
    check(monCnt, 1);
    check({offsetCutoff, offset_removal_enable, absMode, twosComp, misoWeak,
      aux_pin_a_out, aux_pin_a_oe, aux_pin_b_out, aux_pin_b_oe,
      open_drain_pin_out, open_drain_pin_oe}, 32'h177D);
    // short frame in between must store nothing
    scr_spi_master_i.xfer(32'h80000A5C, 32, resp);
    scr_spi_master_i.xfer(32'h80000123, 16, resp);
    scr_spi_master_i.xfer(32'hC0000000, 32, resp);
    scr_spi_master_i.xfer(32'hC0010000, 32, resp);
    check(resp, 32'hFFFF0A5C);
    scr_spi_master_i.xfer(32'hC0010000, 32, resp);
    check(resp, 32'h00000A5C);
    check({adcBufferBias, analog_select_bias}, 32'hA5C);
    // differential mode keeps the idle line driven
    lvdsMode <= 1'b1;
    tick(6);
    check({misoOe, misoWeak}, 32'h2);
    lvdsMode <= 1'b0;
    tick(6);
    // second reset in mid-run
    rstn <= 1'b0;
    tick(8);
    rstn <= 1'b1;
    tick(6);
    check({misoOe, misoWeak, aux_pin_a_out, aux_pin_a_oe, aux_pin_b_out,
      aux_pin_b_oe, open_drain_pin_oe, twosComp}, 32'h14);
    scr_spi_master_i.xfer(32'h6A000000, 32, resp);
    scr_spi_master_i.xfer(32'h6A000000, 32, resp);
    scr_spi_master_i.xfer(32'h6A000000, 32, resp);
    check(resp, 32'h80000000);
    report_and_stop();
  end
endmodule
